// ===== tc8_cfg.svh
`ifndef TC8_CFG_SVH
`define TC8_CFG_SVH
// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define TC8_ADDR_COUNT 3'h0
`define TC8_ADDR_COMPARE 3'h1
`define TC8_ADDR_CONTROL 3'h2
`define TC8_ADDR_ASYNC 3'h3
`define TC8_ADDR_FLAG 3'h4
`define TC8_ADDR_MASK 3'h5
// ------------------------------------------------------------
// field positions and reset values
// ------------------------------------------------------------
`define TC8_FLAG_OVF 0
`define TC8_FLAG_CMP 1
`define TC8_ASYNC_BIT 3
`define TC8_FORCE_BIT 7
`define TC8_BOTTOM 8'h00
`define TC8_MAX 8'hFF
`define TC8_RST_BYTE 8'h00
// ------------------------------------------------------------
// modes and actions
// ------------------------------------------------------------
`define TC8_WGM_NORMAL 2'h0
`define TC8_WGM_PHASE 2'h1
`define TC8_WGM_CTC 2'h2
`define TC8_WGM_FAST 2'h3
`define TC8_COM_OFF 2'h0
`define TC8_COM_TOGGLE 2'h1
`define TC8_COM_CLEAR 2'h2
`define TC8_COM_SET 2'h3
// ------------------------------------------------------------
// prescaler masks (divide by 8, 32, 64, 128, 256, 1024)
// ------------------------------------------------------------
`define TC8_PRE_8 10'h007
`define TC8_PRE_32 10'h01F
`define TC8_PRE_64 10'h03F
`define TC8_PRE_128 10'h07F
`define TC8_PRE_256 10'h0FF
`define TC8_PRE_1024 10'h3FF
`endif

// ===== tc8_pkg.sv
`include "tc8_cfg.svh"
package tc8_pkg;
	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		TC8_NORMAL = `TC8_WGM_NORMAL,
		TC8_PHASE = `TC8_WGM_PHASE,
		TC8_CTC = `TC8_WGM_CTC,
		TC8_FAST = `TC8_WGM_FAST
	} tc8_wgm_type;
	typedef enum logic {
		TC8_UP = 1'b0,
		TC8_DOWN = 1'b1
	} tc8_dir_type;
	// control byte layout: force, wgm0, action, wgm1, clock select
	typedef struct packed {
		logic force_cmp;
		logic wgm_lo;
		logic [1:0] action;
		logic wgm_hi;
		logic [2:0] clk_sel;
	} tc8_ctrl_type;
endpackage

// ===== tc8_timer.sv
// Added by the designer: the address map and the strobed register port.
`timescale 1ns/1ns
`include "tc8_cfg.svh"
// Contract
// - tick is io clock, or oscillator pin when async select bit is one
// - clock select zero stops the counter, no counting nor clearing
// - count value readable and writable at any time
// - cpu count write beats clear, increment and decrement
// - each tick the counter clears, increments or decrements per mode
// - waveform select picks sequence and overflow condition; overflow may interrupt
// - bottom is 0x00, max is 0xFF, top is 0xFF or compare value
// - comparator flags equality of count and compare at all times
// - a match sets the compare flag on the following tick
// - enabled compare flag requests interrupt, cleared when serviced
// - writing one clears the compare flag, zero leaves it
// - waveform generator drives output from match, mode and action bits
// - compare double buffered in pwm modes only
// - buffered compare moves to working register only at top, on the tick at max
// - cpu reaches buffer when buffered, working register otherwise
// - force strobe acts as a match in non-pwm modes
// - forced match sets no flag, leaves counter, updates output like match
// - both requests sit in one flag register, masked individually
// - normal mode counts up, wraps, overflow flag at count zero
// - clear-on-match mode clears count when it equals compare
// - count write blocks matches on the next tick, even when stopped
module tc8_timer
	import tc8_pkg::*;
	#(parameter int PRESC_W = 10)
(
	input wire logic clk, // io clock
	input wire logic reset, // sync, active high
	input wire logic [2:0] addr, // register offset
	input wire logic [7:0] wdata, // write data
	input wire logic wr_en, // write strobe
	input wire logic rd_en, // read strobe
	output logic [7:0] rdata, // read data, one cycle later
	input wire logic osc_pin_in, // oscillator pin in
	output logic osc_pin_out, // oscillator pin out
	input wire logic compare_irq_ack, // compare interrupt serviced
	input wire logic overflow_irq_ack, // overflow interrupt serviced
	output logic compare_irq, // compare request
	output logic overflow_irq, // overflow request
	output logic compare_output_pin, // waveform output
	output logic compare_output_override // output owns the pin
);
	// ------------------------------------------------------------
	// functions
	// ------------------------------------------------------------
	// address decode used by the write paths; reads decode with a case
	function automatic logic hit(input logic [2:0] a, input logic [2:0] o);
		hit = (a == o);
	endfunction

	// prescaler tap select
	function automatic logic presc_hit(input logic [2:0] cs,
		input logic [PRESC_W-1:0] p);
		logic [PRESC_W-1:0] m;
		m = '0;
		case (cs)
			3'h2: m = PRESC_W'(`TC8_PRE_8);
			3'h3: m = PRESC_W'(`TC8_PRE_32);
			3'h4: m = PRESC_W'(`TC8_PRE_64);
			3'h5: m = PRESC_W'(`TC8_PRE_128);
			3'h6: m = PRESC_W'(`TC8_PRE_256);
			3'h7: m = PRESC_W'(`TC8_PRE_1024);
			default: m = '0;
		endcase
		presc_hit = ((p & m) == m);
	endfunction

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	logic [7:0] count_ff, nxt_count;
	logic [7:0] compare_ff, nxt_compare;
	logic [7:0] compare_buf_ff, nxt_compare_buf;
	tc8_ctrl_type ctrl_ff, nxt_ctrl;
	logic async_ff, nxt_async;
	logic [1:0] flags_ff, nxt_flags;
	logic [1:0] mask_ff, nxt_mask;
	tc8_dir_type dir_ff, nxt_dir;
	logic block_ff, nxt_block;
	logic oc_ff, nxt_oc;
	logic [PRESC_W-1:0] presc_ff, nxt_presc;
	logic osc_prev_ff, nxt_osc_prev;
	logic [7:0] rdata_ff, nxt_rdata;
	logic cmp_irq_ff, nxt_cmp_irq;
	logic ovf_irq_ff, nxt_ovf_irq;
	logic ovr_ff, nxt_ovr;
	logic osc_out_ff, nxt_osc_out;

	tc8_wgm_type wgm;
	logic pwm, base, tick, match, at_max, at_bottom;
	logic wr_count, wr_compare, force_evt, cmp_evt, ovf_evt, reload;

	// ------------------------------------------------------------
	// tick and event decode
	// ------------------------------------------------------------
	// osc pin is sampled in clk, so its edge is a clean clk pulse
	always_comb
	begin
		wgm = tc8_wgm_type'({ctrl_ff.wgm_hi, ctrl_ff.wgm_lo});
		pwm = (wgm == TC8_PHASE) || (wgm == TC8_FAST);
		base = async_ff ? (osc_pin_in & ~osc_prev_ff) : 1'b1;
		tick = base && (ctrl_ff.clk_sel != 3'h0)
			&& presc_hit(ctrl_ff.clk_sel, presc_ff);
		match = (count_ff == compare_ff);
		at_max = (count_ff == `TC8_MAX);
		at_bottom = (count_ff == `TC8_BOTTOM);
		wr_count = wr_en && hit(addr, `TC8_ADDR_COUNT);
		wr_compare = wr_en && hit(addr, `TC8_ADDR_COMPARE);
		force_evt = wr_en && hit(addr, `TC8_ADDR_CONTROL)
			&& wdata[`TC8_FORCE_BIT] && !pwm;
		cmp_evt = tick && match && !block_ff;
		ovf_evt = tick && !wr_count && ((wgm == TC8_PHASE) ?
			(at_bottom && dir_ff == TC8_DOWN) : at_max);
		reload = tick && at_max && !(wgm == TC8_PHASE
			&& dir_ff == TC8_DOWN);
	end

	// ------------------------------------------------------------
	// counter and prescaler
	// ------------------------------------------------------------
	always_comb
	begin
		nxt_count = count_ff;
		nxt_dir = dir_ff;
		nxt_osc_prev = osc_pin_in;
		nxt_osc_out = ~osc_pin_in;
		nxt_presc = presc_ff;
		if (ctrl_ff.clk_sel == 3'h0)
			nxt_presc = '0;
		else if (base)
			nxt_presc = presc_ff + PRESC_W'(1);
		if (wr_count)
			nxt_count = wdata;
		else if (tick)
		begin
			case (wgm)
				TC8_CTC:
					nxt_count = match ? `TC8_BOTTOM : count_ff + 8'h01;
				TC8_PHASE:
				begin
					if (dir_ff == TC8_UP && at_max)
					begin
						nxt_dir = TC8_DOWN;
						nxt_count = count_ff - 8'h01;
					end
					else if (dir_ff == TC8_DOWN && at_bottom)
					begin
						nxt_dir = TC8_UP;
						nxt_count = count_ff + 8'h01;
					end
					else if (dir_ff == TC8_DOWN)
						nxt_count = count_ff - 8'h01;
					else
						nxt_count = count_ff + 8'h01;
				end
				default:
					nxt_count = count_ff + 8'h01;
			endcase
		end
	end

	// ------------------------------------------------------------
	// compare buffering and match blocking
	// ------------------------------------------------------------
	// buffering keeps a mid-period write from cutting a pwm pulse short
	always_comb
	begin
		nxt_compare = compare_ff;
		nxt_compare_buf = compare_buf_ff;
		if (wr_compare)
			nxt_compare_buf = wdata;
		if (!pwm)
		begin
			if (wr_compare)
				nxt_compare = wdata;
			else
				nxt_compare_buf = compare_ff;
		end
		else if (reload)
			nxt_compare = compare_buf_ff;
		if (wr_count)
			nxt_block = 1'b1;
		else if (tick)
			nxt_block = 1'b0;
		else
			nxt_block = block_ff;
	end

	// ------------------------------------------------------------
	// waveform generator
	// ------------------------------------------------------------
	// action bits act at once, they are not buffered with compare
	always_comb
	begin
		nxt_oc = oc_ff;
		nxt_ovr = (ctrl_ff.action != `TC8_COM_OFF);
		if (!pwm && (cmp_evt || force_evt))
		begin
			case (ctrl_ff.action)
				`TC8_COM_TOGGLE: nxt_oc = ~oc_ff;
				`TC8_COM_CLEAR: nxt_oc = 1'b0;
				`TC8_COM_SET: nxt_oc = 1'b1;
				default: nxt_oc = oc_ff;
			endcase
		end
		else if (wgm == TC8_FAST && ctrl_ff.action[1])
		begin
			if (cmp_evt)
				nxt_oc = ctrl_ff.action[0];
			else if (tick && at_max)
				nxt_oc = ~ctrl_ff.action[0];
		end
		else if (wgm == TC8_PHASE && ctrl_ff.action[1] && cmp_evt)
			nxt_oc = ctrl_ff.action[0] ^ (dir_ff == TC8_DOWN);
	end

	// ------------------------------------------------------------
	// register file and flags
	// ------------------------------------------------------------
	// set beats clear so an event in the clearing cycle survives
	always_comb
	begin
		logic [1:0] clr;
		clr = 2'b00;
		nxt_ctrl = ctrl_ff;
		nxt_async = async_ff;
		nxt_mask = mask_ff;
		if (wr_en && hit(addr, `TC8_ADDR_CONTROL))
		begin
			nxt_ctrl = tc8_ctrl_type'(wdata);
			nxt_ctrl.force_cmp = 1'b0; // strobe, never stored
		end
		if (wr_en && hit(addr, `TC8_ADDR_ASYNC))
			nxt_async = wdata[`TC8_ASYNC_BIT];
		if (wr_en && hit(addr, `TC8_ADDR_MASK))
			nxt_mask = wdata[1:0];
		if (wr_en && hit(addr, `TC8_ADDR_FLAG))
			clr = wdata[1:0];
		clr[`TC8_FLAG_CMP] = clr[`TC8_FLAG_CMP] | compare_irq_ack;
		clr[`TC8_FLAG_OVF] = clr[`TC8_FLAG_OVF] | overflow_irq_ack;
		nxt_flags = (flags_ff & ~clr) | {cmp_evt, ovf_evt};
		nxt_cmp_irq = flags_ff[`TC8_FLAG_CMP] & mask_ff[`TC8_FLAG_CMP];
		nxt_ovf_irq = flags_ff[`TC8_FLAG_OVF] & mask_ff[`TC8_FLAG_OVF];
		nxt_rdata = `TC8_RST_BYTE;
		if (rd_en)
		begin
			case (addr)
				`TC8_ADDR_COUNT: nxt_rdata = count_ff;
				`TC8_ADDR_COMPARE:
					nxt_rdata = pwm ? compare_buf_ff : compare_ff;
				`TC8_ADDR_CONTROL: nxt_rdata = 8'(ctrl_ff);
				`TC8_ADDR_ASYNC: nxt_rdata = {4'h0, async_ff, 3'h0};
				`TC8_ADDR_FLAG: nxt_rdata = {6'h00, flags_ff};
				`TC8_ADDR_MASK: nxt_rdata = {6'h00, mask_ff};
				default: nxt_rdata = `TC8_RST_BYTE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			count_ff <= `TC8_RST_BYTE;
			compare_ff <= `TC8_RST_BYTE;
			compare_buf_ff <= `TC8_RST_BYTE;
			ctrl_ff <= tc8_ctrl_type'(`TC8_RST_BYTE);
			async_ff <= 1'b0;
			flags_ff <= 2'b00;
			mask_ff <= 2'b00;
			dir_ff <= TC8_UP;
			block_ff <= 1'b0;
			oc_ff <= 1'b0;
			presc_ff <= '0;
			osc_prev_ff <= 1'b0;
			rdata_ff <= `TC8_RST_BYTE;
			cmp_irq_ff <= 1'b0;
			ovf_irq_ff <= 1'b0;
			ovr_ff <= 1'b0;
			osc_out_ff <= 1'b0;
		end
		else
		begin
			count_ff <= nxt_count;
			compare_ff <= nxt_compare;
			compare_buf_ff <= nxt_compare_buf;
			ctrl_ff <= nxt_ctrl;
			async_ff <= nxt_async;
			flags_ff <= nxt_flags;
			mask_ff <= nxt_mask;
			dir_ff <= nxt_dir;
			block_ff <= nxt_block;
			oc_ff <= nxt_oc;
			presc_ff <= nxt_presc;
			osc_prev_ff <= nxt_osc_prev;
			rdata_ff <= nxt_rdata;
			cmp_irq_ff <= nxt_cmp_irq;
			ovf_irq_ff <= nxt_ovf_irq;
			ovr_ff <= nxt_ovr;
			osc_out_ff <= nxt_osc_out;
		end
	end

	assign rdata = rdata_ff;
	assign compare_irq = cmp_irq_ff;
	assign overflow_irq = ovf_irq_ff;
	assign compare_output_pin = oc_ff;
	assign compare_output_override = ovr_ff;
	assign osc_pin_out = osc_out_ff;

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	sequence wrap_tick_s;
		tick && wgm == TC8_NORMAL && at_max && !wr_count;
	endsequence

	stop_hold_a: assert property (
		ctrl_ff.clk_sel == 3'h0 && !wr_count |=> $stable(count_ff))
		else $error("counter moved while stopped");
	write_prio_a: assert property (
		wr_count |=> count_ff == $past(wdata))
		else $error("count write lost");
	normal_wrap_a: assert property (
		wrap_tick_s |=> count_ff == `TC8_BOTTOM && flags_ff[`TC8_FLAG_OVF])
		else $error("normal wrap or overflow wrong");
	ctc_clear_a: assert property (
		tick && wgm == TC8_CTC && match && !wr_count |=> count_ff == 8'h00)
		else $error("no clear on match");
	cmp_flag_a: assert property (
		tick && match && !block_ff |=> flags_ff[`TC8_FLAG_CMP])
		else $error("compare flag not set");
	match_block_a: assert property (
		tick && block_ff |=> $past(flags_ff[1]) || !flags_ff[1])
		else $error("match after count write");
	flag_clear_a: assert property (
		wr_en && hit(addr, `TC8_ADDR_FLAG) && wdata[1] && !cmp_evt
		|=> !flags_ff[`TC8_FLAG_CMP])
		else $error("compare flag not cleared");
	force_tog_a: assert property (
		force_evt && ctrl_ff.action == `TC8_COM_TOGGLE && !cmp_evt
		|=> oc_ff != $past(oc_ff))
		else $error("forced toggle missing");
	force_flag_a: assert property (
		force_evt && !cmp_evt && !tick && !wr_count
		|=> $stable(count_ff) && flags_ff[1] == $past(flags_ff[1]))
		else $error("force touched flag or count");
	irq_req_a: assert property (
		flags_ff[1] && mask_ff[1] |=> compare_irq)
		else $error("compare irq missing");
	dbuf_hold_a: assert property (
		pwm && wr_compare && !reload |=> $stable(compare_ff))
		else $error("buffered write hit working compare");
endmodule

// ===== timer_counter_8bit_compare_bench.sv
`timescale 1ns/1ns
`include "tc8_cfg.svh"
module timer_counter_8bit_compare_bench import tc8_pkg::*;;
	// ------------------------------------------------------------
	// stimulus signals and scoreboard
	// ------------------------------------------------------------
	logic clk = 1'h0;
	logic reset = 1'h1;
	logic [2:0] addr = 3'h0;
	logic [7:0] wdata = 8'h00;
	logic wr_en = 1'h0;
	logic rd_en = 1'h0;
	logic osc_in = 1'h0;
	logic cack = 1'h0;
	logic oack = 1'h0;
	logic [7:0] rdata;
	logic osc_out, cirq, oirq, pin, ovr;
	logic rd_ff = 1'h0;
	logic [7:0] exp_q[$];
	int n_errors = 0;
	int cmp_count = 0;

	tc8_timer #(.PRESC_W(10)) u_dut (
		.clk(clk), .reset(reset), .addr(addr), .wdata(wdata),
		.wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
		.osc_pin_in(osc_in), .osc_pin_out(osc_out),
		.compare_irq_ack(cack), .overflow_irq_ack(oack),
		.compare_irq(cirq), .overflow_irq(oirq),
		.compare_output_pin(pin), .compare_output_override(ovr)
	);

	// 100 ns period
	initial
		forever #50 clk = ~clk;

	// ------------------------------------------------------------
	// bus tasks; strobes stay up between back to back cycles
	// ------------------------------------------------------------
	task automatic check(input logic [7:0] got, input logic [7:0] exp,
		input string msg);
		cmp_count++;
		if (got !== exp)
		begin
			$display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
			n_errors++;
		end
	endtask

	task automatic summarize();
		$display("errors %0d comparisons %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		addr <= a;
		wdata <= d;
		wr_en <= 1'h1;
		rd_en <= 1'h0;
		@(posedge clk);
	endtask

	task automatic rd(input logic [2:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		addr <= a;
		rd_en <= 1'h1;
		wr_en <= 1'h0;
		@(posedge clk);
	endtask

	task automatic idle(input int n);
		wr_en <= 1'h0;
		rd_en <= 1'h0;
		repeat (n) @(posedge clk);
	endtask

	// park at the falling edge so registered outputs have settled
	task automatic half();
		wr_en <= 1'h0;
		rd_en <= 1'h0;
		@(negedge clk);
	endtask

	// t ticks at divide by one: the stop write edge still ticks
	task automatic run(input logic [7:0] c, input int t);
		wr(`TC8_ADDR_CONTROL, c);
		if (t > 1)
			idle(t - 1);
		wr(`TC8_ADDR_CONTROL, c & 8'hF8);
	endtask

	task automatic wait_irq(input bit c);
		bit hit;
		hit = 1'b0;
		wr_en <= 1'h0;
		rd_en <= 1'h0;
		for (int i = 0; i < 8 && !hit; i++)
		begin
			@(negedge clk);
			hit = ((c ? cirq : oirq) === 1'h1);
		end
		check({7'h00, hit}, 8'h01, "interrupt request");
		if (!hit)
			summarize();
		else
			@(posedge clk);
	endtask

	task automatic ack(input bit c);
		wr_en <= 1'h0;
		cack <= c;
		oack <= !c;
		@(posedge clk);
		cack <= 1'h0;
		oack <= 1'h0;
	endtask

	// read data stand only in the cycle after the strobe
	always @(posedge clk)
		rd_ff <= rd_en;
	always @(negedge clk)
		if (rd_ff)
			check(rdata, exp_q.pop_front(), "read data");

	// hang guard
	initial
	begin
		repeat (100000) @(posedge clk);
		$display("MISMATCH %0t run timed out", $time);
		n_errors++;
		summarize();
	end

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial
	begin
		logic [7:0] v;
		logic [7:0] acts [4] = '{8'h20, 8'h30, 8'h10, 8'h10};
		void'($urandom(32'hE593));
		repeat (20) @(posedge clk);
		reset <= 1'h0;
		idle(1);
		for (int a = 0; a < 8; a++)
			rd(a[2:0], 8'h00);
		// stopped counter keeps cpu values
		repeat (4)
		begin
			v = 8'($urandom);
			wr(`TC8_ADDR_COUNT, v);
			wr(`TC8_ADDR_COMPARE, ~v);
			idle(3);
			rd(`TC8_ADDR_COUNT, v);
			rd(`TC8_ADDR_COMPARE, ~v);
		end
		// normal mode wrap and overflow request
		wr(`TC8_ADDR_COMPARE, 8'h80);
		wr(`TC8_ADDR_COUNT, 8'hFE);
		run(8'h01, 2);
		rd(`TC8_ADDR_COUNT, 8'h00);
		rd(`TC8_ADDR_FLAG, 8'h01);
		wr(`TC8_ADDR_MASK, 8'h01);
		wait_irq(1'b0);
		ack(1'b0);
		rd(`TC8_ADDR_FLAG, 8'h00);
		wr(`TC8_ADDR_MASK, 8'h00);
		// count write lands on a tick edge and wins
		wr(`TC8_ADDR_CONTROL, 8'h01);
		wr(`TC8_ADDR_COUNT, 8'h40);
		wr(`TC8_ADDR_CONTROL, 8'h00);
		rd(`TC8_ADDR_COUNT, 8'h41);
		// clear on match with toggle output
		wr(`TC8_ADDR_CONTROL, 8'h18);
		wr(`TC8_ADDR_COMPARE, 8'h03);
		wr(`TC8_ADDR_COUNT, 8'h00);
		run(8'h19, 6);
		rd(`TC8_ADDR_COUNT, 8'h02);
		half();
		check({7'h00, pin}, 8'h01, "toggled output");
		check({7'h00, ovr}, 8'h01, "output override");
		@(posedge clk);
		wr(`TC8_ADDR_FLAG, 8'h00);
		rd(`TC8_ADDR_FLAG, 8'h02);
		wr(`TC8_ADDR_MASK, 8'h02);
		wait_irq(1'b1);
		ack(1'b1);
		rd(`TC8_ADDR_FLAG, 8'h00);
		wr(`TC8_ADDR_MASK, 8'h00);
		// forced matches: clear, set, toggle twice
		for (int i = 0; i < 4; i++)
		begin
			wr(`TC8_ADDR_CONTROL, acts[i]);
			wr(`TC8_ADDR_CONTROL, acts[i] | 8'h80);
			half();
			check({7'h00, pin}, {7'h00, i[0]}, "forced output");
			@(posedge clk);
		end
		rd(`TC8_ADDR_COUNT, 8'h02);
		rd(`TC8_ADDR_FLAG, 8'h00);
		// force is ignored in fast pwm
		wr(`TC8_ADDR_CONTROL, 8'h68);
		wr(`TC8_ADDR_CONTROL, 8'hE8);
		half();
		check({7'h00, pin}, 8'h01, "force in pwm");
		@(posedge clk);
		rd(`TC8_ADDR_CONTROL, 8'h68);
		// count write hides the match on the next tick only
		wr(`TC8_ADDR_CONTROL, 8'h00);
		wr(`TC8_ADDR_COMPARE, 8'h10);
		wr(`TC8_ADDR_COUNT, 8'h10);
		run(8'h01, 1);
		rd(`TC8_ADDR_FLAG, 8'h00);
		wr(`TC8_ADDR_COUNT, 8'h0F);
		run(8'h01, 2);
		rd(`TC8_ADDR_FLAG, 8'h02);
		wr(`TC8_ADDR_FLAG, 8'h02);
		rd(`TC8_ADDR_FLAG, 8'h00);
		// pwm writes go to the buffer, working value still matches
		wr(`TC8_ADDR_COMPARE, 8'h21);
		wr(`TC8_ADDR_CONTROL, 8'h48);
		wr(`TC8_ADDR_COMPARE, 8'h05);
		rd(`TC8_ADDR_COMPARE, 8'h05);
		wr(`TC8_ADDR_COUNT, 8'h20);
		run(8'h49, 2);
		rd(`TC8_ADDR_FLAG, 8'h02);
		// phase pwm turns at max and counts down
		wr(`TC8_ADDR_CONTROL, 8'h40);
		wr(`TC8_ADDR_COUNT, 8'hFE);
		run(8'h41, 4);
		rd(`TC8_ADDR_COUNT, 8'hFC);
		// prescaler taps and oscillator edges drive the count
		wr(`TC8_ADDR_CONTROL, 8'h00);
		wr(`TC8_ADDR_FLAG, 8'h03);
		wr(`TC8_ADDR_COUNT, 8'h00);
		// divide by eight: two ticks in sixteen cycles
		run(8'h02, 16);
		rd(`TC8_ADDR_COUNT, 8'h02);
		wr(`TC8_ADDR_COUNT, 8'h00);
		wr(`TC8_ADDR_ASYNC, 8'h08);
		rd(`TC8_ADDR_ASYNC, 8'h08);
		wr(`TC8_ADDR_CONTROL, 8'h01);
		half();
		check({7'h00, osc_out}, 8'h01, "oscillator drive");
		check({7'h00, ovr}, 8'h00, "override off");
		@(posedge clk);
		idle(8);
		repeat (3)
		begin
			osc_in <= 1'h1;
			idle(4);
			osc_in <= 1'h0;
			idle(4);
		end
		wr(`TC8_ADDR_CONTROL, 8'h00);
		rd(`TC8_ADDR_COUNT, 8'h03);
		wr(`TC8_ADDR_ASYNC, 8'h00);
		idle(3);
		summarize();
	end
endmodule
